//--- phase_offset_and_sequencing_ctrl_tb.sv
// Self-checking bench for the node and master joined on one bus
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
	n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module phase_offset_and_sequencing_ctrl_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        grp_en = 1'b0;
	logic        host_wr = 1'b0;
	logic        share = 1'b0;
	logic        sync = 1'b0;
	logic        link = 1'b0;
	logic [6:0]  hprev = 7'h00;
	logic [6:0]  hnext = 7'h00;
	logic [4:0]  ph_strap = 5'h00;
	logic [4:0]  sq_strap = 5'h00;
	logic [4:0]  sh_idx = 5'h00;
	logic [4:0]  host_ph = 5'h00;
	logic [6:0]  addr = 7'h05;
	logic [6:0]  lo = 7'h05;
	logic [6:0]  hi = 7'h05;
	logic        on_o, start_o, sense_o, auto_o, seen_o;
	logic [4:0]  phase_o;
	logic [1:0]  sync_o, role_o;
	int          n_errors = 0;
	int          checks_done = 0;
	int          seen_cnt = 0;
	int          i, n;
	logic [4:0]  pcode [7] = '{5'h1d, 5'h1e, 5'h1f, 5'h00, 5'h0e, 5'h0f, 5'h1c};
	logic [4:0]  pexp [7] = '{5'h04, 5'h00, 5'h08, 5'h01, 5'h0f, 5'h01, 5'h0e};
	logic [4:0]  scode [4] = '{5'h01, 5'h03, 5'h07, 5'h0b};
	logic [1:0]  rexp [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
	logic [1:0]  yexp [4] = '{2'h1, 2'h0, 2'h1, 2'h2};
	logic [6:0]  lo_t [4] = '{7'h05, 7'h05, 7'h04, 7'h04};
	logic [6:0]  hi_t [4] = '{7'h05, 7'h06, 7'h05, 7'h04};
	logic        lk_t [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	logic        on_t [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
	logic        off_t [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	int          seen_t [4] = '{2, 1, 1, 2};

	always #2.5 clk = ~clk;
	always @(posedge clk) if (seen_o === 1'b1) seen_cnt++;

	pos_bus_if pos_bus_if_inst ();
	pos_node pos_node_inst (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
		.CLK_EN_IN(1'b1), .PHASE_STRAP_IN(ph_strap), .SEQ_STRAP_IN(sq_strap),
		.BUS_ADDR_IN(addr), .GROUP_LOW_IN(lo), .GROUP_HIGH_IN(hi),
		.SHARE_MEMBER_IN(share), .SHARE_INDEX_IN(sh_idx),
		.HOST_PHASE_WR_IN(host_wr), .HOST_PHASE_IN(host_ph),
		.HOST_LINK_MODE_IN(link), .HOST_PREV_IN(hprev), .HOST_NEXT_IN(hnext),
		.SYNC_EDGE_IN(sync), .PERIOD_CYC_IN(16'h0040), .POWER_GOOD_IN(1'b1),
		.OUTPUT_ON_OUT(on_o), .PERIOD_START_OUT(start_o), .PHASE_OUT(phase_o),
		.SW_SENSE_OUT(sense_o), .SYNC_DIR_OUT(sync_o), .ROLE_OUT(role_o),
		.AUTO_SEQ_OUT(auto_o), .bus(pos_bus_if_inst));
	pos_master pos_master_inst (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
		.CLK_EN_IN(1'b1), .GROUP_EN_IN(grp_en), .EVENT_SEEN_OUT(seen_o),
		.bus(pos_bus_if_inst));
	pos_bus_properties pos_bus_properties_inst (.SYS_CLK_IN(clk),
		.RESET_N_IN(rst_n), .enable(pos_bus_if_inst.enable),
		.evt_node_out(pos_bus_if_inst.evt_node_out),
		.evt_node_oe(pos_bus_if_inst.evt_node_oe),
		.evt_mst_out(pos_bus_if_inst.evt_mst_out),
		.evt_mst_oe(pos_bus_if_inst.evt_mst_oe),
		.evt_line(pos_bus_if_inst.evt_line));

	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Straps are taken only at the first edge after reset release
	task automatic boot(input logic [4:0] p, input logic [4:0] s);
		@(negedge clk);
		rst_n = 1'b0;
		ph_strap = p;
		sq_strap = s;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask

	task automatic host_write(input logic [4:0] v, input logic [4:0] e);
		host_ph = v;
		host_wr = 1'b1;
		@(negedge clk);
		host_wr = 1'b0;
		@(negedge clk);
		`CHK("host phase", e, phase_o)
	endtask

	initial begin
		for (i = 0; i < 7; i++) begin
			boot(pcode[i], pos_pkg::STRAP_OPEN);
			`CHK("strap phase", pexp[i], phase_o)
			`CHK("sense", 1'(pcode[i] >= 5'h0f && pcode[i] <= 5'h1c), sense_o)
		end
		ph_strap = 5'h00;
		repeat (3) @(negedge clk);
		`CHK("held phase", 5'h0e, phase_o)
		host_write(5'h10, 5'h10);
		host_write(5'h11, 5'h10);
		boot(5'h03, pos_pkg::STRAP_OPEN);
		sync = 1'b1;
		@(negedge clk);
		sync = 1'b0;
		n = 0;
		while (start_o !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		// Period 64 at 90 degrees, counted from the edge after the pulse
		`CHK("start delay", 64 * 4 / 16 + 1, n)
		share = 1'b1;
		sh_idx = 5'h07;
		boot(5'h00, 5'h04);
		`CHK("share phase", 5'h07, phase_o)
		`CHK("auto refused", 1'b0, auto_o)
		share = 1'b0;
		for (i = 0; i < 4; i++) begin
			boot(5'h00, scode[i]);
			`CHK("role", rexp[i], role_o)
			`CHK("sync dir", yexp[i], sync_o)
		end
		hprev = 7'h05;
		hnext = 7'h05;
		for (i = 0; i < 4; i++) begin
			lo = lo_t[i];
			hi = hi_t[i];
			link = lk_t[i];
			boot(5'h00, 5'h04);
			`CHK("seq phase", lk_t[i] ? 5'h01 : 5'h05, phase_o)
			seen_cnt = 0;
			grp_en = 1'b1;
			repeat (20) @(negedge clk);
			`CHK("on order", on_t[i], on_o)
			grp_en = 1'b0;
			repeat (20) @(negedge clk);
			`CHK("off order", off_t[i], on_o)
			`CHK("events", seen_t[i], seen_cnt)
		end
		close_out();
	end
endmodule

//--- pos_bus_if.sv
// Shared enable and open-drain event bus joining node and group master
`timescale 1ns/1ps
interface pos_bus_if;
	logic enable;
	logic evt_node_out;
	logic evt_node_oe;
	logic evt_mst_out;
	logic evt_mst_oe;
	logic evt_line;
	// Open-drain wired-and with pull-up
	assign evt_line = !((evt_node_oe && !evt_node_out) ||
		(evt_mst_oe && !evt_mst_out));
	modport node (input enable, input evt_line,
		output evt_node_out, output evt_node_oe);
	modport master (output enable, input evt_line,
		output evt_mst_out, output evt_mst_oe);
endinterface

//--- pos_bus_properties.sv
// Checks on the shared enable and open-drain event bus
`timescale 1ns/1ps
module pos_bus_properties (
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RESET_N_IN,
	// Bus signals
	input wire logic enable,
	input wire logic evt_node_out,
	input wire logic evt_node_oe,
	input wire logic evt_mst_out,
	input wire logic evt_mst_oe,
	input wire logic evt_line
);
	logic [3:0] since_r;

	// Cycles since the shared enable last changed, saturating
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN)
			since_r <= 4'hf;
		else if ($changed(enable))
			since_r <= 4'h0;
		else if (since_r != 4'hf)
			since_r <= since_r + 4'h1;
	end

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	sequence node_pulse;
		evt_node_oe ##1 !evt_node_oe;
	endsequence

	node_drive_low_a: assert property (evt_node_oe |-> !evt_node_out)
		else $error("node drives event bus high");
	mst_drive_low_a: assert property (evt_mst_oe |-> !evt_mst_out)
		else $error("master drives event bus high");
	pulse_single_a: assert property ($rose(evt_node_oe) |-> node_pulse)
		else $error("node event pulse not one cycle");
	pulse_quiet_a: assert property ($fell(evt_node_oe) |-> !evt_node_oe [*8])
		else $error("node event repeated");
	pulse_after_en_a: assert property ($rose(evt_node_oe) |-> since_r < 4'h8)
		else $error("node event without enable change");
	line_pulled_a: assert property (evt_node_oe || evt_mst_oe |-> !evt_line)
		else $error("event line not low while pulled");
	line_idle_a: assert property (!evt_node_oe && !evt_mst_oe |-> evt_line)
		else $error("event line not idle high");
	line_release_a: assert property ($fell(evt_node_oe) && !evt_mst_oe |-> evt_line)
		else $error("event line held after release");
endmodule

//--- pos_master.sv
// Group side: drives the shared enable and watches the event bus
`timescale 1ns/1ps
module pos_master (
	// Clock and reset
	input  wire logic SYS_CLK_IN,
	input  wire logic RESET_N_IN,
	input  wire logic CLK_EN_IN,
	// User side
	input  wire logic GROUP_EN_IN,
	output logic      EVENT_SEEN_OUT,
	// Bus
	pos_bus_if.master bus
);
	typedef struct packed {
		logic en;
		logic evt_prev;
		logic seen;
	} pos_mst_t;

	pos_mst_t s_r;
	pos_mst_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.en = GROUP_EN_IN;
		s_nxt.evt_prev = bus.evt_line;
		s_nxt.seen = s_r.evt_prev && !bus.evt_line;
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s_r <= '{evt_prev: 1'b1, default: '0};
		end else if (CLK_EN_IN) begin
			s_r <= s_nxt;
		end
	end

	assign bus.enable = s_r.en;
	assign bus.evt_mst_out = 1'b1;
	assign bus.evt_mst_oe = 1'b0;
	assign EVENT_SEEN_OUT = s_r.seen;
endmodule

//--- pos_node.sv
// Phase offset and output sequencing logic of one power controller
`timescale 1ns/1ps
module pos_node #(
	parameter int ADDR_W = pos_pkg::ADDR_W
) (
	// Clock and reset
	input  wire logic                         SYS_CLK_IN,
	input  wire logic                         RESET_N_IN,
	input  wire logic                         CLK_EN_IN,
	// Straps and configuration
	input  wire logic [pos_pkg::STRAP_W-1:0]  PHASE_STRAP_IN,
	input  wire logic [pos_pkg::STRAP_W-1:0]  SEQ_STRAP_IN,
	input  wire logic [ADDR_W-1:0]            BUS_ADDR_IN,
	input  wire logic [ADDR_W-1:0]            GROUP_LOW_IN,
	input  wire logic [ADDR_W-1:0]            GROUP_HIGH_IN,
	input  wire logic                         SHARE_MEMBER_IN,
	input  wire logic [pos_pkg::PHASE_W-1:0]  SHARE_INDEX_IN,
	// Host override
	input  wire logic                         HOST_PHASE_WR_IN,
	input  wire logic [pos_pkg::PHASE_W-1:0]  HOST_PHASE_IN,
	input  wire logic                         HOST_LINK_MODE_IN,
	input  wire logic [ADDR_W-1:0]            HOST_PREV_IN,
	input  wire logic [ADDR_W-1:0]            HOST_NEXT_IN,
	// Switching clock
	input  wire logic                         SYNC_EDGE_IN,
	input  wire logic [pos_pkg::PERIOD_W-1:0] PERIOD_CYC_IN,
	// Power stage status
	input  wire logic                         POWER_GOOD_IN,
	// Status
	output logic                              OUTPUT_ON_OUT,
	output logic                              PERIOD_START_OUT,
	output logic [pos_pkg::PHASE_W-1:0]       PHASE_OUT,
	output logic                              SW_SENSE_OUT,
	output logic [1:0]                        SYNC_DIR_OUT,
	output logic [1:0]                        ROLE_OUT,
	output logic                              AUTO_SEQ_OUT,
	// Event bus
	pos_bus_if.node                           bus
);
	typedef struct packed {
		logic                         sampled;
		logic [pos_pkg::PHASE_W-1:0]  strap_ph;
		logic                         sw_sense;
		logic [1:0]                   sync_dir;
		logic [1:0]                   role;
		logic                         host_ph_v;
		logic [pos_pkg::PHASE_W-1:0]  host_ph;
		pos_pkg::pos_state_t          st;
		logic [ADDR_W-1:0]            cur;
		logic                         evt_prev;
		logic                         pulse;
		logic                         on;
		logic [pos_pkg::PERIOD_W-1:0] dly;
		logic                         dly_run;
		logic                         start;
	} pos_node_t;

	pos_node_t s_r;
	pos_node_t s_nxt;
	logic auto_seq;
	logic [pos_pkg::PHASE_W-1:0] phase;
	logic [ADDR_W-1:0] first_addr;
	logic [ADDR_W-1:0] last_addr;
	logic [ADDR_W-1:0] my_turn_on;
	logic [ADDR_W-1:0] my_turn_off;
	logic [pos_pkg::STRAP_W-1:0] grp;
	localparam int PROD_W = pos_pkg::PERIOD_W + pos_pkg::PHASE_W;
	logic [PROD_W-1:0] prod;
	logic evt_fall;

	// Autonomous only when strapped and not a sharing member
	assign auto_seq = (s_r.role != 2'(pos_pkg::ROLE_OFF)) &&
		!SHARE_MEMBER_IN && !HOST_LINK_MODE_IN;
	assign evt_fall = s_r.evt_prev && !bus.evt_line;

	always_comb begin
		if (s_r.host_ph_v) begin
			phase = s_r.host_ph;
		end else if (SHARE_MEMBER_IN) begin
			phase = SHARE_INDEX_IN & pos_pkg::PH_MAX_STRAP;
		end else if (auto_seq) begin
			phase = {1'b0, BUS_ADDR_IN[pos_pkg::PHASE_W-2:0]};
		end else begin
			phase = s_r.strap_ph;
		end
	end

	// Host links override address ordering
	assign first_addr = HOST_LINK_MODE_IN ? HOST_PREV_IN : GROUP_LOW_IN;
	assign last_addr = HOST_LINK_MODE_IN ? HOST_NEXT_IN : GROUP_HIGH_IN;
	assign my_turn_on = BUS_ADDR_IN;
	assign my_turn_off = BUS_ADDR_IN;
	assign grp = SEQ_STRAP_IN / pos_pkg::SEQ_GRP;
	assign prod = PROD_W'(PERIOD_CYC_IN) * PROD_W'(phase);

	always_comb begin
		s_nxt = s_r;
		s_nxt.evt_prev = bus.evt_line;
		s_nxt.pulse = 1'b0;
		s_nxt.start = 1'b0;
		if (!s_r.sampled) begin
			s_nxt.sampled = 1'b1;
			s_nxt.sw_sense = 1'b0;
			case (PHASE_STRAP_IN)
				pos_pkg::STRAP_LOW: s_nxt.strap_ph = pos_pkg::PH_90;
				pos_pkg::STRAP_OPEN: s_nxt.strap_ph = pos_pkg::PH_0;
				pos_pkg::STRAP_HIGH: s_nxt.strap_ph = pos_pkg::PH_180;
				default: begin
					if (PHASE_STRAP_IN >= pos_pkg::RES_SW_FIRST) begin
						s_nxt.sw_sense = 1'b1;
						s_nxt.strap_ph = PHASE_STRAP_IN -
							pos_pkg::RES_SW_FIRST + 5'h01;
					end else begin
						s_nxt.strap_ph = PHASE_STRAP_IN + 5'h01;
					end
				end
			endcase
			// Sync direction and role from sequencing strap
			if (SEQ_STRAP_IN > pos_pkg::RES_LAST) begin
				s_nxt.sync_dir = 2'(SEQ_STRAP_IN - pos_pkg::STRAP_LOW);
				s_nxt.role = 2'(pos_pkg::ROLE_OFF);
			end else begin
				s_nxt.sync_dir = 2'(SEQ_STRAP_IN % pos_pkg::SEQ_GRP);
				case (grp)
					5'h01, 5'h05: s_nxt.role = 2'(pos_pkg::ROLE_FIRST);
					5'h02, 5'h06: s_nxt.role = 2'(pos_pkg::ROLE_LAST);
					5'h03, 5'h07: s_nxt.role = 2'(pos_pkg::ROLE_MIDDLE);
					default: s_nxt.role = 2'(pos_pkg::ROLE_OFF);
				endcase
			end
		end
		if (HOST_PHASE_WR_IN && HOST_PHASE_IN <= pos_pkg::PH_MAX_HOST) begin
			s_nxt.host_ph_v = 1'b1;
			s_nxt.host_ph = HOST_PHASE_IN;
		end
		// Phase delay after common sync edge
		if (SYNC_EDGE_IN) begin
			// Divide by the sixteen steps of a full turn
			s_nxt.dly = prod[PROD_W-2:pos_pkg::PHASE_W-1];
			s_nxt.dly_run = 1'b1;
		end else if (s_r.dly_run) begin
			if (s_r.dly == '0) begin
				s_nxt.start = 1'b1;
				s_nxt.dly_run = 1'b0;
			end else begin
				s_nxt.dly = s_r.dly - 1'b1;
			end
		end
		case (s_r.st)
			pos_pkg::ST_IDLE: begin
				if (bus.enable && (auto_seq || HOST_LINK_MODE_IN)) begin
					s_nxt.cur = first_addr;
					s_nxt.st = pos_pkg::ST_WAIT_ON;
				end else if (bus.enable) begin
					s_nxt.on = 1'b1;
					s_nxt.st = pos_pkg::ST_ON;
				end
			end
			pos_pkg::ST_WAIT_ON: begin
				if (!bus.enable) begin
					s_nxt.cur = last_addr;
					s_nxt.st = pos_pkg::ST_WAIT_OFF;
				end else if (s_r.cur == my_turn_on) begin
					s_nxt.on = 1'b1;
					if (POWER_GOOD_IN) begin
						s_nxt.pulse = 1'b1;
						s_nxt.st = pos_pkg::ST_ON;
					end
				end else if (evt_fall) begin
					s_nxt.cur = s_r.cur + 1'b1;
				end
			end
			pos_pkg::ST_ON: begin
				if (!bus.enable && (auto_seq || HOST_LINK_MODE_IN)) begin
					s_nxt.cur = last_addr;
					s_nxt.st = pos_pkg::ST_WAIT_OFF;
				end else if (!bus.enable) begin
					s_nxt.on = 1'b0;
					s_nxt.st = pos_pkg::ST_IDLE;
				end else if (evt_fall && !s_r.on) begin
					s_nxt.st = pos_pkg::ST_ON;
				end
			end
			pos_pkg::ST_WAIT_OFF: begin
				if (s_r.cur == my_turn_off) begin
					s_nxt.on = 1'b0;
					s_nxt.pulse = 1'b1;
					s_nxt.st = pos_pkg::ST_OFF_DONE;
				end else if (evt_fall) begin
					s_nxt.cur = s_r.cur - 1'b1;
				end
			end
			pos_pkg::ST_OFF_DONE: begin
				if (!bus.enable && !evt_fall) begin
					s_nxt.st = pos_pkg::ST_IDLE;
				end
			end
			default: s_nxt.st = pos_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s_r <= '{st: pos_pkg::ST_IDLE, evt_prev: 1'b1, default: '0};
		end else if (CLK_EN_IN) begin
			s_r <= s_nxt;
		end
	end

	// One-cycle pull on the event line when this unit finishes its step
	assign bus.evt_node_out = 1'b0;
	assign bus.evt_node_oe = s_r.pulse;
	assign OUTPUT_ON_OUT = s_r.on;
	assign PERIOD_START_OUT = s_r.start;
	assign PHASE_OUT = phase;
	assign SW_SENSE_OUT = s_r.sw_sense;
	assign SYNC_DIR_OUT = s_r.sync_dir;
	assign ROLE_OUT = s_r.role;
	assign AUTO_SEQ_OUT = auto_seq;
endmodule

//--- pos_pkg.sv
// Constants and types shared by the sequencing node and the testbench
// Notes on behaviour
// - Strap sets phase zero to 337.5 degrees
// - Three-level strap: low 90, open 0, high 180
// - Resistor index selects phase and sensing method
// - Sharing members get automatic phase offsets
// - Host may write phase up to 360
// - All units share one switching clock
// - Event bus sequencing refused on sharing rails; code still sequences a sharing member in host link mode
// - Integrator gives consecutive addresses, no gaps
// - Autonomous mode derives phase from address
// - Turn-on runs lowest address upward
// - Turn-off runs highest address downward
// - Host links predecessor and successor explicitly
// - Shared enable starts on and off sequences
// - Sequencing strap sets sync direction and method
// - Strap gives first, middle, last or disabled
package pos_pkg;
	localparam int STRAP_W = 5;
	localparam int PHASE_W = 5;
	localparam int ADDR_W = 7;
	localparam int PERIOD_W = 16;
	// Three-level strap codes on the index inputs
	localparam logic [STRAP_W-1:0] STRAP_LOW = 5'h1d;
	localparam logic [STRAP_W-1:0] STRAP_OPEN = 5'h1e;
	localparam logic [STRAP_W-1:0] STRAP_HIGH = 5'h1f;
	// Phase in 22.5 degree steps
	localparam logic [PHASE_W-1:0] PH_0 = 5'h00;
	localparam logic [PHASE_W-1:0] PH_90 = 5'h04;
	localparam logic [PHASE_W-1:0] PH_180 = 5'h08;
	localparam logic [PHASE_W-1:0] PH_MAX_STRAP = 5'h0f;
	localparam logic [PHASE_W-1:0] PH_MAX_HOST = 5'h10;
	localparam logic [PHASE_W-1:0] PH_STEPS = 5'h10;
	// Resistor indices 0..14 inductor sensing, 15..28 switch sensing
	localparam logic [STRAP_W-1:0] RES_SW_FIRST = 5'h0f;
	localparam logic [STRAP_W-1:0] RES_LAST = 5'h1c;
	// Sequencing strap resistor index groups of three
	localparam logic [STRAP_W-1:0] SEQ_GRP = 5'h03;
	localparam int RESET_SETTLE_CYC = 4;
	typedef enum logic [1:0] {
		SYNC_IN   = 2'h0,
		SYNC_AUTO = 2'h1,
		SYNC_OUT  = 2'h2
	} pos_sync_t;
	typedef enum logic [1:0] {
		ROLE_OFF    = 2'h0,
		ROLE_FIRST  = 2'h1,
		ROLE_MIDDLE = 2'h2,
		ROLE_LAST   = 2'h3
	} pos_role_t;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WAIT_ON = 5'h02,
		ST_ON = 5'h04,
		ST_WAIT_OFF = 5'h08,
		ST_OFF_DONE = 5'h10
	} pos_state_t;
endpackage
